// File: core/cpu_regs_cfg.svh
// constants for the cpu programming model and memory map
`ifndef CPU_REGS_CFG_SVH
`define CPU_REGS_CFG_SVH
// register indices on the plain register port
`define REG_ACC        4'h0
`define REG_INDEX      4'h1
`define REG_PC_LOW     4'h2
`define REG_PC_HIGH    4'h3
`define REG_SP         4'h4
`define REG_FLAGS      4'h5
`define REG_OP         4'h6
`define REG_OPERAND    4'h7
`define REG_IRQ        4'h8
`define REG_DECODE_LO  4'h9
`define REG_DECODE_HI  4'hA
`define REG_REGION     4'hB
`define REG_STATUS     4'hC
// stack pointer layout
`define SP_TOP         8'hFF
`define SP_BASE        8'hC0
`define SP_LOW_MASK    8'h3F
// flag bit positions
`define FLG_C          0
`define FLG_Z          1
`define FLG_N          2
`define FLG_I          3
`define FLG_H          4
// memory map bounds
`define MAP_RAM_LO     16'h0020
`define MAP_RAM_HI     16'h00FF
`define MAP_ROM_LO     16'h1000
`define MAP_ROM_HI     16'h1EFF
`define MAP_BOOT_LO    16'h1F00
`define MAP_BOOT_HI    16'h1FEF
`define MAP_VEC_LO     16'h1FF0
`define MAP_VEC_HI     16'h1FFF
`define MAP_IO_HI      16'h001F
`define ERASED_BYTE    8'hFF
`define RESET_VEC_LO   16'h1FFE
`endif

// File: core/cpu_regs_pkg.sv
// types shared by the cpu register block
package cpu_regs_pkg;
  typedef enum logic [3:0] {
    OP_NONE, OP_ADD, OP_ADC, OP_SUB, OP_AND, OP_LOAD, OP_LSL, OP_ROR,
    OP_BTST, OP_RSP, OP_CALL, OP_RTS, OP_INT, OP_RTI, OP_CLI, OP_SEI
  } op_t;
  typedef enum logic [2:0] {
    RGN_IO, RGN_RAM, RGN_ROM, RGN_BOOT, RGN_VEC, RGN_NONE
  } region_t;
endpackage : cpu_regs_pkg

// File: core/stack_if.sv
// push and pull requests between the core and the stack engine
interface stack_if;
  logic       push;
  logic       pull;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [5:0] ptr;
  modport core  (output push, pull, wdata, input rdata, ptr);
  modport stack (input push, pull, wdata, output rdata, ptr);
endinterface : stack_if

// File: core/stack_engine.sv
// page-zero stack with six-bit wrapping pointer
`include "cpu_regs_cfg.svh"
module stack_engine (
  input  wire logic ref_clk,   // core clock
  input  wire logic rstn,      // async reset, low
  input  wire logic sp_reload, // reset stack pointer instruction
  stack_if.stack    stk        // push and pull port
);
  logic [5:0] ptr;
  logic [7:0] mem [0:63];
  assign stk.ptr   = ptr;
  // pull reads above the free slot: increment before pull
  assign stk.rdata = mem[ptr + 6'd1];

  // pointer: wraps silently, no overflow flag by design
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ptr <= 6'h3F;
    end else if (sp_reload) begin
      ptr <= 6'h3F;
    end else if (stk.push) begin
      ptr <= ptr - 6'd1;
    end else if (stk.pull) begin
      ptr <= ptr + 6'd1;
    end
  end

  // storage holds through low-power modes, no reset needed
  always_ff @(posedge ref_clk) begin
    if (stk.push) begin
      mem[ptr] <= stk.wdata;
    end
  end

  stack_top_a: assert property (
    @(posedge ref_clk) disable iff (!rstn) $rose(rstn) |-> ptr == 6'h3F)
    else $error("stack pointer not at top after reset");
  stack_wrap_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (stk.push && !sp_reload && ptr == 6'h00) |=> ptr == 6'h3F)
    else $error("stack pointer did not wrap");
endmodule : stack_engine

// File: core/map_decode.sv
// memory map region decoder
`include "cpu_regs_cfg.svh"
module map_decode (
  input  wire logic [15:0]         addr,      // byte address
  input  wire logic                prog_var,  // programmable variant
  input  wire logic                test_mode, // special test mode
  output cpu_regs_pkg::region_t    region,    // decoded region
  output logic                     pcr_ok     // prog control usable
);
  import cpu_regs_pkg::*;
  // page zero io, ram, user rom, boot rom and vectors
  always_comb begin
    region = RGN_NONE;
    if (addr <= `MAP_IO_HI) begin
      region = RGN_IO;
    end else if (addr <= `MAP_RAM_HI) begin
      region = RGN_RAM;
    end else if (addr >= `MAP_ROM_LO && addr <= `MAP_ROM_HI) begin
      region = RGN_ROM;
    end else if (addr >= `MAP_BOOT_LO && addr <= `MAP_BOOT_HI) begin
      region = RGN_BOOT;
    end else if (addr >= `MAP_VEC_LO) begin
      if (addr <= `MAP_VEC_HI) begin
        region = RGN_VEC;
      end
    end
  end
  // absent on mask variant, hidden outside test modes
  assign pcr_ok = prog_var & test_mode;
endmodule : map_decode

// File: core/cpu_regs.sv
// cpu programming model: registers, flags, stack and map
// What this block does
// - eight-bit accumulator holds operands and results.
// - eight-bit index register, also usable as temporary storage.
// - sixteen-bit program counter addresses the next byte fetched.
// - stack pointer goes to top on reset and reload instruction.
// - decrement after each push, increment before each pull.
// - stack address is fixed upper bits plus six pointer bits.
// - pointer wraps past 64 bytes with no error shown.
// - call pushes two bytes, interrupt entry pushes five.
// - program counter low byte first, then high, then rest; reverse on pull.
// - five-bit flag register, four result flags and interrupt mask.
// - half carry set on carry from bit 3 into bit 4.
// - mask holds interrupts; request stays latched until mask clears.
// - negative flag follows result sign.
// - zero flag set when result is zero.
// - carry from add, borrow, shifts, rotates and bit tests.
// - 224 bytes of ram at top of page zero; top 64 are stack.
// - ram keeps contents through stop and wait.
// - decode 3840 bytes user memory and 16-byte vector area.
// - 240-byte boot rom just below the vectors.
// - erased programmable memory reads as all ones.
// - programming control only in test modes, absent on mask variant.
// - reset sets interrupt mask and vectors to reset start.
// - interrupt entry stacks registers and masks; return restores them.
`include "cpu_regs_cfg.svh"
module cpu_regs (
  input  wire logic        ref_clk,   // core clock, 250 MHz
  input  wire logic        rstn,      // async reset, active low
  input  wire logic [3:0]  reg_addr,  // register index
  input  wire logic [7:0]  reg_wdata, // write data
  input  wire logic        reg_wr,    // write strobe
  input  wire logic        reg_rd,    // read strobe
  output logic      [7:0]  reg_rdata, // read data, cycle after strobe
  input  wire logic        irq_req,   // hardware interrupt request pulse
  input  wire logic        prog_var,  // programmable variant strap
  input  wire logic        test_mode, // special test mode
  input  wire logic        erased,    // addressed cell is erased
  output logic             busy,      // stack sequence running
  output logic             irq_take   // interrupt being entered, pulse
);
  import cpu_regs_pkg::*;

  logic [7:0]  acc;
  logic [7:0]  index_reg;
  logic [15:0] pc;
  logic [4:0]  flags;
  logic [7:0]  operand;
  logic [15:0] decode_addr;
  logic        irq_latch;
  logic        sp_reload;
  logic [2:0]  seq_cnt;
  logic        seq_pull;
  logic [2:0]  seq_len;
  region_t     region;
  logic        pcr_ok;
  stack_if     stk ();

  stack_engine u_stack (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .sp_reload (sp_reload),
    .stk       (stk)
  );

  map_decode u_map (
    .addr      (decode_addr),
    .prog_var  (prog_var),
    .test_mode (test_mode),
    .region    (region),
    .pcr_ok    (pcr_ok)
  );

  // operation issue: writing an opcode triggers it
  logic  op_go;
  op_t   op;
  assign op_go = reg_wr && reg_addr == `REG_OP && !busy;
  assign op    = op_t'(reg_wdata[3:0]);
  assign sp_reload = op_go && op == OP_RSP;

  // alu results
  logic [8:0] sum;
  logic [4:0] half;
  logic [8:0] diff;
  logic       cin;
  assign cin  = (op == OP_ADC) ? flags[`FLG_C] : 1'b0;
  assign sum  = {1'b0, acc} + {1'b0, operand} + {8'h00, cin};
  assign half = {1'b0, acc[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
  assign diff = {1'b0, acc} - {1'b0, operand};

  logic [7:0] next_acc;
  logic [4:0] next_flags;
  logic       flags_set;
  // flag and accumulator update per operation
  always_comb begin
    next_acc   = acc;
    next_flags = flags;
    flags_set  = 1'b0;
    case (op)
      OP_ADD, OP_ADC: begin
        next_acc = sum[7:0];
        next_flags[`FLG_H] = half[4];
        next_flags[`FLG_C] = sum[8];
        flags_set = 1'b1;
      end
      OP_SUB: begin
        next_acc = diff[7:0];
        next_flags[`FLG_C] = diff[8];
        flags_set = 1'b1;
      end
      OP_AND: begin
        next_acc  = acc & operand;
        flags_set = 1'b1;
      end
      OP_LOAD: begin
        next_acc  = operand;
        flags_set = 1'b1;
      end
      OP_LSL: begin
        next_acc = {acc[6:0], 1'b0};
        next_flags[`FLG_C] = acc[7];
        flags_set = 1'b1;
      end
      OP_ROR: begin
        next_acc = {flags[`FLG_C], acc[7:1]};
        next_flags[`FLG_C] = acc[0];
        flags_set = 1'b1;
      end
      OP_BTST: begin
        // bit test copies the selected bit into carry only
        next_flags[`FLG_C] = acc[operand[2:0]];
      end
      OP_CLI:  next_flags[`FLG_I] = 1'b0;
      OP_SEI:  next_flags[`FLG_I] = 1'b1;
      default: next_flags = flags;
    endcase
    if (flags_set) begin
      next_flags[`FLG_N] = next_acc[7];
      next_flags[`FLG_Z] = next_acc == 8'h00;
    end
  end

  // stack sequencer: pc low, pc high, index, acc, flags
  logic take_irq;
  assign take_irq = irq_latch && !flags[`FLG_I] && !busy && !op_go;
  assign irq_take = take_irq;
  assign busy     = seq_cnt != 3'd0;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      seq_cnt  <= 3'd0;
      seq_pull <= 1'b0;
      seq_len  <= 3'd0;
    end else if (take_irq) begin
      seq_cnt  <= 3'd5;
      seq_len  <= 3'd5;
      seq_pull <= 1'b0;
    end else if (op_go && (op == OP_CALL || op == OP_RTS)) begin
      seq_cnt  <= 3'd2;
      seq_len  <= 3'd2;
      seq_pull <= op == OP_RTS;
    end else if (op_go && op == OP_RTI) begin
      seq_cnt  <= 3'd5;
      seq_len  <= 3'd5;
      seq_pull <= 1'b1;
    end else if (busy) begin
      seq_cnt  <= seq_cnt - 3'd1;
    end
  end

  // step 0 is first byte pushed; pulls walk it backwards
  logic [2:0] step;
  assign step = seq_pull ? seq_cnt - 3'd1 : seq_len - seq_cnt;
  assign stk.push = busy && !seq_pull;
  assign stk.pull = busy && seq_pull;
  always_comb begin
    case (step)
      3'd0:    stk.wdata = pc[7:0];
      3'd1:    stk.wdata = pc[15:8];
      3'd2:    stk.wdata = index_reg;
      3'd3:    stk.wdata = acc;
      // entry needs the mask clear, so the pre-entry mask was clear
      3'd4:    stk.wdata = {3'b000, flags & ~(5'h01 << `FLG_I)};
      default: stk.wdata = 8'h00;
    endcase
  end

  // request latch: held while masked; new request wins over taking
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_latch <= 1'b0;
    end else if (irq_req) begin
      irq_latch <= 1'b1;
    end else if (take_irq) begin
      irq_latch <= 1'b0;
    end
  end

  // accumulator
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      acc <= 8'h00;
    end else if (stk.pull && step == 3'd3) begin
      acc <= stk.rdata;
    end else if (reg_wr && reg_addr == `REG_ACC) begin
      acc <= reg_wdata;
    end else if (op_go) begin
      acc <= next_acc;
    end
  end

  // index register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      index_reg <= 8'h00;
    end else if (stk.pull && step == 3'd2) begin
      index_reg <= stk.rdata;
    end else if (reg_wr && reg_addr == `REG_INDEX) begin
      index_reg <= reg_wdata;
    end
  end

  // program counter
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pc <= `RESET_VEC_LO;
    end else if (stk.pull && step == 3'd0) begin
      pc[7:0] <= stk.rdata;
    end else if (stk.pull && step == 3'd1) begin
      pc[15:8] <= stk.rdata;
    end else if (reg_wr && reg_addr == `REG_PC_LOW) begin
      pc[7:0] <= reg_wdata;
    end else if (reg_wr && reg_addr == `REG_PC_HIGH) begin
      pc[15:8] <= reg_wdata;
    end else if (op_go && op != OP_NONE) begin
      pc <= pc + 16'h0001;
    end
  end

  // flags
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flags <= 5'b01000;
    end else if (take_irq) begin
      flags[`FLG_I] <= 1'b1;
    end else if (stk.pull && step == 3'd4) begin
      flags <= stk.rdata[4:0];
    end else if (reg_wr && reg_addr == `REG_FLAGS) begin
      flags <= reg_wdata[4:0];
    end else if (op_go) begin
      flags <= next_flags;
    end
  end

  // operand and decode address
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      operand     <= 8'h00;
      decode_addr <= 16'h0000;
    end else if (reg_wr && reg_addr == `REG_OPERAND) begin
      operand <= reg_wdata;
    end else if (reg_wr && reg_addr == `REG_DECODE_LO) begin
      decode_addr[7:0] <= reg_wdata;
    end else if (reg_wr && reg_addr == `REG_DECODE_HI) begin
      decode_addr[15:8] <= reg_wdata;
    end
  end

  // read mux; erased program cells read all ones
  logic [7:0] rd_mux;
  logic       prog_cell;
  assign prog_cell = region == RGN_ROM || region == RGN_VEC;
  always_comb begin
    case (reg_addr)
      `REG_ACC:     rd_mux = acc;
      `REG_INDEX:   rd_mux = index_reg;
      `REG_PC_LOW:  rd_mux = pc[7:0];
      `REG_PC_HIGH: rd_mux = pc[15:8];
      `REG_SP:      rd_mux = `SP_BASE | {2'b00, stk.ptr};
      `REG_FLAGS:   rd_mux = {3'b000, flags};
      `REG_IRQ:     rd_mux = {7'h00, irq_latch};
      `REG_DECODE_LO: rd_mux = decode_addr[7:0];
      `REG_DECODE_HI: rd_mux = decode_addr[15:8];
      `REG_REGION:  rd_mux = (prog_var && erased && prog_cell) ?
                             `ERASED_BYTE : {5'h00, region};
      `REG_STATUS:  rd_mux = {6'h00, pcr_ok, busy};
      default:      rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // checks run on the core clock and sleep while reset is low
  default clocking core_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  mask_on_reset_a: assert property ($rose(rstn) |-> flags[`FLG_I])
    else $error("mask not set after reset");
  irq_masked_a: assert property (flags[`FLG_I] |-> !irq_take)
    else $error("interrupt taken while masked");
  irq_mask_set_a: assert property (irq_take |=> flags[`FLG_I])
    else $error("mask not set on interrupt entry");
  stacked_mask_a: assert property (
    irq_take |=> ##4 !stk.wdata[`FLG_I])
    else $error("stacked flags hold the entry mask");
  irq_five_a: assert property (
    irq_take |=> stk.push [*5] ##1 !stk.push)
    else $error("interrupt entry not five pushes");
  call_two_a: assert property (
    (op_go && op == OP_CALL) |=> stk.push [*2] ##1 !stk.push)
    else $error("call not two pushes");
  pc_low_first_a: assert property (
    irq_take |=> stk.wdata == pc[7:0] ##1 stk.wdata == pc[15:8])
    else $error("pc byte order wrong");
  zero_flag_a: assert property (
    (op_go && op == OP_LOAD && !take_irq) |=>
      flags[`FLG_Z] == (acc == 8'h00))
    else $error("zero flag wrong");
  neg_flag_a: assert property (
    (op_go && op == OP_LOAD && !take_irq) |=> flags[`FLG_N] == acc[7])
    else $error("negative flag wrong");
  half_carry_a: assert property (
    (op_go && op == OP_ADD && !take_irq) |=> flags[`FLG_H] ==
      ($past(acc[3:0]) + $past(operand[3:0]) > 5'd15))
    else $error("half carry wrong");
  irq_held_a: assert property (
    (irq_latch && flags[`FLG_I] && !irq_take) |=> irq_latch)
    else $error("latched request lost");

  irq_entry_c: cover property (irq_take);
  rti_c: cover property (op_go && op == OP_RTI);
  rts_c: cover property (op_go && op == OP_RTS);
  wrap_c: cover property (stk.push && stk.ptr == 6'h00);
endmodule : cpu_regs

// File: sim/cpu_regs_tb.sv
// self-checking bench for the cpu register block
`include "cpu_regs_cfg.svh"
module cpu_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cpu_regs_pkg::*;

  typedef struct {
    logic [7:0] a, f, o;
    op_t        op;
    logic [7:0] ea, ef;
  } alu_row_t;

  logic       ref_clk, rstn, reg_wr, reg_rd, irq_req;
  logic       prog_var, test_mode, erased, busy, irq_take;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  int         miscompares, comparisons, take_cnt;

  // acc, flags, operand, op, expected acc, expected flags (H I N Z C)
  alu_row_t rows [12] = '{
    '{8'h08, 8'h00, 8'h08, OP_ADD,  8'h10, 8'h10},
    '{8'hFF, 8'h00, 8'h01, OP_ADD,  8'h00, 8'h13},
    '{8'h7F, 8'h01, 8'h00, OP_ADC,  8'h80, 8'h14},
    '{8'h00, 8'h10, 8'h01, OP_SUB,  8'hFF, 8'h15},
    '{8'hF0, 8'h09, 8'h0F, OP_AND,  8'h00, 8'h0B},
    '{8'h12, 8'h02, 8'h80, OP_LOAD, 8'h80, 8'h04},
    '{8'h81, 8'h00, 8'h00, OP_LSL,  8'h02, 8'h01},
    '{8'h01, 8'h01, 8'h00, OP_ROR,  8'h80, 8'h05},
    '{8'h55, 8'h1F, 8'h00, OP_NONE, 8'h55, 8'h1F},
    '{8'h55, 8'h00, 8'h00, OP_SEI,  8'h55, 8'h08},
    '{8'h55, 8'h1F, 8'h00, OP_CLI,  8'h55, 8'h17},
    '{8'h04, 8'h00, 8'h02, OP_BTST, 8'h04, 8'h01}
  };
  // map probe addresses and the region codes they should give
  logic [15:0] map_addr [11] = '{16'h001F, 16'h0020, 16'h00FF, 16'h0100,
    16'h0FFF, 16'h1000, 16'h1EFF, 16'h1F00, 16'h1FEF, 16'h1FF0, 16'h1FFF};
  logic [7:0]  map_exp  [11] = '{8'h00, 8'h01, 8'h01, 8'h05, 8'h05,
    8'h02, 8'h02, 8'h03, 8'h03, 8'h04, 8'h04};

  cpu_regs u_dut (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .irq_req   (irq_req),
    .prog_var  (prog_var),
    .test_mode (test_mode),
    .erased    (erased),
    .busy      (busy),
    .irq_take  (irq_take)
  );

  // 250 MHz core clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // counts interrupt entries, a masked request must not add any
  always @(posedge ref_clk) begin
    if (irq_take === 1'b1) take_cnt <= take_cnt + 1;
  end

  task finish_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // strobe stays up so back-to-back writes need no gap
  task wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    {reg_wr, reg_rd} <= 2'b10;
    @(posedge ref_clk);
  endtask : wr

  task rd(input logic [3:0] a, input logic [7:0] e);
    reg_addr <= a;
    {reg_wr, reg_rd} <= 2'b01;
    @(posedge ref_clk);
    {reg_wr, reg_rd} <= 2'b00;
    #1 chk(reg_rdata, e);
    @(posedge ref_clk);
  endtask : rd

  task idle(input int n);
    repeat (n) begin
      {reg_wr, reg_rd} <= 2'b00;
      @(posedge ref_clk);
    end
  endtask : idle

  // called at the edge that took the request; counts busy cycles
  task wait_busy(input int exp_n);
    int n;
    n = 0;
    {reg_wr, reg_rd} <= 2'b00;
    #1;
    while (busy === 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 20) begin
      miscompares++;
      finish_test();
    end
    chk(n[7:0], exp_n[7:0]);
    @(posedge ref_clk);
  endtask : wait_busy

  // hang guard
  initial begin
    repeat (30000) @(posedge ref_clk);
    miscompares++;
    finish_test();
  end

  initial begin
    int n;
    {rstn, reg_wr, reg_rd, irq_req, prog_var, test_mode, erased} = 7'h00;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    miscompares = 0;
    comparisons = 0;
    take_cnt = 0;
    repeat (12) @(posedge ref_clk);
    chk(reg_rdata, 8'h00);
    chk({7'h00, busy}, 8'h00);
    rstn <= 1'b1;
    @(posedge ref_clk);
    // reset values
    rd(`REG_SP, 8'hFF);
    rd(`REG_FLAGS, 8'h08);
    rd(`REG_PC_LOW, 8'hFE);
    rd(`REG_PC_HIGH, 8'h1F);
    wr(`REG_PC_LOW, 8'h34);
    wr(`REG_PC_HIGH, 8'h12);
    rd(`REG_PC_LOW, 8'h34);
    rd(`REG_PC_HIGH, 8'h12);
    // sp is read-only, unmapped indices read zero
    wr(`REG_SP, 8'h00);
    wr(4'hD, 8'hAA);
    rd(`REG_SP, 8'hFF);
    rd(4'hD, 8'h00);
    // arithmetic and flag table
    foreach (rows[i]) begin
      wr(`REG_ACC, rows[i].a);
      wr(`REG_FLAGS, rows[i].f);
      wr(`REG_OPERAND, rows[i].o);
      wr(`REG_OP, {4'h0, rows[i].op});
      idle(2);
      rd(`REG_ACC, rows[i].ea);
      rd(`REG_FLAGS, rows[i].ef);
    end
    // memory map, mask variant first
    foreach (map_addr[i]) begin
      wr(`REG_DECODE_LO, map_addr[i][7:0]);
      wr(`REG_DECODE_HI, map_addr[i][15:8]);
      idle(1);
      rd(`REG_REGION, map_exp[i]);
    end
    // erased cells read all ones only on the programmable variant
    erased <= 1'b1;
    idle(1);
    rd(`REG_REGION, 8'h04);
    prog_var <= 1'b1;
    idle(1);
    rd(`REG_REGION, 8'hFF);
    wr(`REG_DECODE_HI, 8'h1F);
    wr(`REG_DECODE_LO, 8'h00);
    idle(1);
    rd(`REG_REGION, 8'h03);
    rd(`REG_STATUS, 8'h00);
    test_mode <= 1'b1;
    idle(1);
    rd(`REG_STATUS, 8'h02);
    prog_var <= 1'b0;
    idle(1);
    rd(`REG_STATUS, 8'h00);
    // a call while busy is dropped, so only two bytes go down
    wr(`REG_OP, {4'h0, OP_RSP});
    idle(1);
    rd(`REG_SP, 8'hFF);
    wr(`REG_PC_LOW, 8'h34);
    wr(`REG_PC_HIGH, 8'h12);
    wr(`REG_OP, {4'h0, OP_CALL});
    wr(`REG_OP, {4'h0, OP_CALL});
    idle(3);
    rd(`REG_SP, 8'hFD);
    // return pulls back the pc that the call pushed, already stepped
    wr(`REG_PC_HIGH, 8'h00);
    wr(`REG_OP, {4'h0, OP_RTS});
    wait_busy(2);
    rd(`REG_PC_LOW, 8'h35);
    rd(`REG_PC_HIGH, 8'h12);
    rd(`REG_SP, 8'hFF);
    // 64 bytes of calls bring the pointer back round, no error
    wr(`REG_OP, {4'h0, OP_RSP});
    repeat (32) begin
      wr(`REG_OP, {4'h0, OP_CALL});
      wait_busy(2);
    end
    rd(`REG_SP, 8'hFF);
    rd(`REG_STATUS, 8'h00);
    // masked request stays latched until the mask clears
    wr(`REG_OP, {4'h0, OP_RSP});
    wr(`REG_ACC, 8'hA5);
    wr(`REG_INDEX, 8'h3C);
    wr(`REG_PC_LOW, 8'h78);
    wr(`REG_PC_HIGH, 8'h56);
    wr(`REG_FLAGS, 8'h08);
    {reg_wr, reg_rd} <= 2'b00;
    irq_req <= 1'b1;
    @(posedge ref_clk);
    irq_req <= 1'b0;
    idle(4);
    chk(take_cnt[7:0], 8'h00);
    rd(`REG_IRQ, 8'h01);
    wr(`REG_FLAGS, 8'h01);
    {reg_wr, reg_rd} <= 2'b00;
    n = 0;
    #1;
    while (irq_take !== 1'b1 && n < 10) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 10) begin
      miscompares++;
      finish_test();
    end
    @(posedge ref_clk);
    wait_busy(5);
    chk(take_cnt[7:0], 8'h01);
    rd(`REG_FLAGS, 8'h09);
    rd(`REG_SP, 8'hFA);
    // scramble, then return must restore every stacked register
    wr(`REG_ACC, 8'h00);
    wr(`REG_INDEX, 8'h00);
    wr(`REG_FLAGS, 8'h08);
    wr(`REG_PC_HIGH, 8'h00);
    wr(`REG_OP, {4'h0, OP_RTI});
    wait_busy(5);
    rd(`REG_ACC, 8'hA5);
    rd(`REG_INDEX, 8'h3C);
    rd(`REG_FLAGS, 8'h01);
    rd(`REG_PC_LOW, 8'h78);
    rd(`REG_PC_HIGH, 8'h56);
    rd(`REG_SP, 8'hFF);
    // second reset in mid-run
    wr(`REG_OP, {4'h0, OP_CALL});
    rstn <= 1'b0;
    {reg_wr, reg_rd} <= 2'b00;
    repeat (3) @(posedge ref_clk);
    chk({7'h00, busy}, 8'h00);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rd(`REG_SP, 8'hFF);
    rd(`REG_FLAGS, 8'h08);
    rd(`REG_ACC, 8'h00);
    finish_test();
  end
endmodule : cpu_regs_tb
